// ### rtl/wgsc_top.v
// Waveform generator state control with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "wgsc_consts.vh"
module wgsc_top #(
  parameter [20:0] RELAY_SETTLE_CYC = `WGSC_RELAY_SETTLE_CYC
) (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        temp_alarm,
  input  wire        pll_locked,
  input  wire        data_underflow,
  input  wire        gen_complete,
  input  wire [15:0] eng_sample,
  input  wire [15:0] osp_sample,
  input  wire        osp_enable,
  input  wire        function_line_zero_i,
  output reg         function_line_zero_o,
  output reg         function_line_zero_oe,
  input  wire        function_line_one_i,
  output reg         function_line_one_o,
  output reg         function_line_one_oe,
  output wire [7:0]  bp_trig_o,
  output wire [7:0]  bp_trig_oe,
  output reg         clk_out_oe,
  output reg         clk_in_en,
  output reg         sclk_src_ext,
  output reg         tb_tune_ext,
  output reg  [7:0]  rate_div,
  output reg         engine_run,
  output reg         started_evt,
  output wire [15:0] dac_data,
  output wire [3:0]  dac_atten,
  output reg         analog_out_pair_zero_en,
  output reg         analog_out_pair_one_en,
  output reg         out_term_gnd,
  output wire        relay_settling,
  output reg         power_down,
  output reg  [1:0]  led_color,
  output reg  [5:0]  gen_state
);
  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_WAIT  = 6'h02;
  localparam [5:0] ST_FIRST = 6'h04;
  localparam [5:0] ST_GEN   = 6'h08;
  localparam [5:0] ST_DONE  = 6'h10;
  localparam [5:0] ST_HWERR = 6'h20;

  function wgsc_mapped;
    input [7:0] a;
    begin
      wgsc_mapped = (a == `WGSC_REG_CTRL) || (a == `WGSC_REG_CFG) ||
                    (a == `WGSC_REG_DGAIN) || (a == `WGSC_REG_AGAIN) ||
                    (a == `WGSC_REG_STATUS);
    end
  endfunction

  reg [3:0]  sync1;
  reg [3:0]  sync2;
  reg [1:0]  fl_prev;
  reg        loaded;
  reg        out_en;
  reg [8:0]  cfg_p;
  reg [8:0]  cfg_a;
  reg [7:0]  rdiv_p;
  reg [15:0] dg_p;
  reg [15:0] dg_a;
  reg [15:0] ag_p;
  reg [15:0] ag_a;
  reg        therm;
  reg        pll_err;
  reg        unf_err;
  reg [5:0]  next_gen_state;

  // Pins from outside the clock domain: thermal, lock, two trigger lines
  always @(posedge mclk) begin
    if (!rst_n) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else if (ce) begin
      sync1 <= {function_line_one_i, function_line_zero_i, pll_locked, temp_alarm};
      sync2 <= sync1;
    end
  end

  wire temp_hot = sync2[0];
  wire lock_ok  = sync2[1];
  wire fl0      = sync2[2];
  wire fl1      = sync2[3];
  // Triggers are sampled on the same clock that paces the engine
  wire fl0_edge = fl0 & ~fl_prev[0];
  wire fl1_edge = fl1 & ~fl_prev[1];

  // APB decode; the slave answers in the first access cycle
  wire acc       = psel & penable;
  wire setup     = psel & ~penable;
  wire ctrl_hit  = (paddr == `WGSC_REG_CTRL);
  wire cmd_reset = acc & pwrite & ctrl_hit & pwdata[`WGSC_CTRL_RESET];
  wire err_core  = ~wgsc_mapped(paddr) |
                   (therm & ~cmd_reset) |
                   ((gen_state == ST_HWERR) & ~pwrite &
                    (paddr == `WGSC_REG_STATUS));
  assign pready  = 1'b1;
  assign pslverr = acc & err_core;
  wire wr_ok     = acc & pwrite & ~err_core;

  wire cmd_load   = wr_ok & ctrl_hit & pwdata[`WGSC_CTRL_LOAD];
  wire cmd_init   = wr_ok & ctrl_hit & pwdata[`WGSC_CTRL_INIT];
  wire cmd_abort  = wr_ok & ctrl_hit & pwdata[`WGSC_CTRL_ABORT];
  wire cmd_swtrig = wr_ok & ctrl_hit & pwdata[`WGSC_CTRL_SWTRIG];
  wire cmd_commit = wr_ok & ctrl_hit & pwdata[`WGSC_CTRL_COMMIT];
  wire cmd_outen  = wr_ok & ctrl_hit & pwdata[`WGSC_CTRL_OUTEN_UPD];
  wire cfg_wr     = wr_ok & (paddr == `WGSC_REG_CFG);
  wire dg_wr      = wr_ok & (paddr == `WGSC_REG_DGAIN);
  wire ag_wr      = wr_ok & (paddr == `WGSC_REG_AGAIN);

  // Software may edit pending settings in any state unless the thermal latch is set
  wire dynamic  = (gen_state == ST_WAIT) | (gen_state == ST_FIRST) |
                  (gen_state == ST_GEN);
  wire [1:0] tsrc = cfg_a[`WGSC_CFG_TSRC_HI:`WGSC_CFG_TSRC_LO];
  wire cont_mode  = cfg_a[`WGSC_CFG_CONT];

  reg ext_trig;
  always @* begin
    case (tsrc)
      `WGSC_TSRC_SW:  ext_trig = cmd_swtrig;
      `WGSC_TSRC_FL0: ext_trig = fl0_edge;
      `WGSC_TSRC_FL1: ext_trig = fl1_edge;
      default:        ext_trig = 1'b0;
    endcase
  end
  wire trig_hit = (tsrc == `WGSC_TSRC_IMM) | ext_trig;

  // Lock loss only counts once the clocking is in use
  wire err_evt = temp_hot | data_underflow | (dynamic & ~lock_ok);

  always @* begin
    next_gen_state = gen_state;
    case (gen_state)
      ST_IDLE: begin
        if (cmd_init)
          next_gen_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (cmd_abort)
          next_gen_state = ST_IDLE;
        else if (trig_hit)
          next_gen_state = ST_FIRST;
      end
      ST_FIRST: begin
        if (cmd_abort)
          next_gen_state = ST_IDLE;
        else
          next_gen_state = ST_GEN;
      end
      ST_GEN: begin
        if (cmd_abort)
          next_gen_state = ST_IDLE;
        else if (gen_complete & ~cont_mode)
          next_gen_state = ST_DONE;
      end
      ST_DONE: begin
        if (cmd_abort)
          next_gen_state = ST_IDLE;
      end
      ST_HWERR: next_gen_state = ST_HWERR;
      default:  next_gen_state = ST_IDLE;
    endcase
    if (err_evt)
      next_gen_state = ST_HWERR;
    if (cmd_reset)
      next_gen_state = ST_IDLE;
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      gen_state   <= ST_IDLE;
      fl_prev     <= 2'h0;
      started_evt <= 1'b0;
      engine_run  <= 1'b0;
    end else if (ce) begin
      gen_state <= next_gen_state;
      fl_prev   <= {fl1, fl0};
      started_evt <= ~cmd_reset & ~cmd_abort & ~err_evt &
                     (((gen_state == ST_WAIT) & trig_hit) |
                      ((gen_state == ST_GEN) & ext_trig));
      // A non-thermal error leaves the engine running as it was
      if (next_gen_state == ST_HWERR)
        engine_run <= engine_run & ~temp_hot;
      else
        engine_run <= (next_gen_state == ST_FIRST) | (next_gen_state == ST_GEN);
    end
  end

  // Latched errors: a new event in the reset cycle still sets the flag
  always @(posedge mclk) begin
    if (!rst_n) begin
      therm   <= 1'b0;
      pll_err <= 1'b0;
      unf_err <= 1'b0;
    end else if (ce) begin
      therm   <= temp_hot | (therm & ~cmd_reset);
      pll_err <= (dynamic & ~lock_ok) | (pll_err & ~cmd_reset);
      unf_err <= data_underflow | (unf_err & ~cmd_reset);
    end
  end

  // Configuration: pending copies, and active copies that drive hardware
  always @(posedge mclk) begin
    if (!rst_n || (ce && cmd_reset)) begin
      if (!rst_n)
        loaded <= 1'b0;
      out_en <= 1'b1;
      cfg_p  <= `WGSC_CFG_RST;
      cfg_a  <= `WGSC_CFG_RST;
      rdiv_p <= `WGSC_RDIV_RST;
      rate_div <= `WGSC_RDIV_RST;
      dg_p   <= `WGSC_DGAIN_RST;
      dg_a   <= `WGSC_DGAIN_RST;
      ag_p   <= `WGSC_AGAIN_RST;
      ag_a   <= `WGSC_AGAIN_RST;
    end else if (ce) begin
      if (cmd_load)
        loaded <= 1'b1;
      if (cmd_outen)
        out_en <= pwdata[`WGSC_CTRL_OUTEN];
      if (cfg_wr) begin
        cfg_p  <= pwdata[8:0];
        rdiv_p <= pwdata[`WGSC_CFG_RDIV_HI:`WGSC_CFG_RDIV_LO];
      end
      if (dg_wr) begin
        dg_p <= pwdata[15:0];
        if (dynamic)
          dg_a <= pwdata[15:0];
      end
      if (ag_wr) begin
        ag_p <= pwdata[15:0];
        if (dynamic)
          ag_a <= pwdata[15:0];
      end
      // Commit only from idle; otherwise idle keeps the applied setup
      if (cmd_commit && gen_state == ST_IDLE) begin
        cfg_a    <= cfg_p;
        rate_div <= rdiv_p;
        dg_a     <= dg_p;
        ag_a     <= ag_p;
      end
    end
  end

  // Pin and output stage
  wire ch_on = loaded & out_en & ~therm;
  always @(posedge mclk) begin
    if (!rst_n) begin
      analog_out_pair_zero_en <= 1'b0;
      analog_out_pair_one_en  <= 1'b0;
      out_term_gnd            <= 1'b1;
      clk_out_oe              <= 1'b0;
      clk_in_en               <= 1'b0;
      sclk_src_ext            <= 1'b0;
      tb_tune_ext             <= 1'b0;
      function_line_zero_o    <= 1'b0;
      function_line_zero_oe   <= 1'b0;
      function_line_one_o     <= 1'b0;
      function_line_one_oe    <= 1'b0;
      power_down              <= 1'b0;
      led_color               <= `WGSC_LED_OFF;
    end else if (ce) begin
      analog_out_pair_zero_en <= ch_on;
      analog_out_pair_one_en  <= ch_on;
      out_term_gnd            <= ~ch_on;
      clk_out_oe              <= cfg_a[`WGSC_CFG_CLKOUT_EN];
      clk_in_en               <= cfg_a[`WGSC_CFG_CLKIN_EN];
      sclk_src_ext            <= cfg_a[`WGSC_CFG_SCLK_EXT];
      tb_tune_ext             <= cfg_a[`WGSC_CFG_TB_EXT];
      function_line_zero_o    <= started_evt;
      function_line_zero_oe   <= cfg_a[`WGSC_CFG_FL0_OE];
      function_line_one_o     <= started_evt;
      function_line_one_oe    <= cfg_a[`WGSC_CFG_FL1_OE];
      power_down              <= therm;
      if (gen_state == ST_HWERR || therm || pll_err || unf_err)
        led_color <= `WGSC_LED_RED;
      else if (gen_state == ST_WAIT)
        led_color <= `WGSC_LED_AMBER;
      else if (gen_state == ST_FIRST || gen_state == ST_GEN)
        led_color <= `WGSC_LED_GREEN;
      else
        led_color <= `WGSC_LED_OFF;
    end
  end

  // Backplane trigger lines are never driven by this block
  assign bp_trig_o  = 8'h00;
  assign bp_trig_oe = 8'h00;

  // Read data is captured in the setup cycle and held through access
  always @(posedge mclk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (ce && setup) begin
      case (paddr)
        `WGSC_REG_CTRL:   prdata <= {30'h00000000, out_en, loaded};
        `WGSC_REG_CFG:    prdata <= {8'h00, rdiv_p, 7'h00, cfg_p};
        `WGSC_REG_DGAIN:  prdata <= {16'h0000, dg_p};
        `WGSC_REG_AGAIN:  prdata <= {16'h0000, ag_p};
        `WGSC_REG_STATUS: prdata <= {16'h0000, relay_settling, led_color,
                                     therm, pll_err, unf_err, loaded, out_en,
                                     2'h0, gen_state};
        default:          prdata <= 32'h00000000;
      endcase
    end
  end

  // Samples keep flowing through gain when out_en alone opens the relay
  wire [15:0] sample_sel = osp_enable ? osp_sample : eng_sample;

  wgsc_gain u_gain (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .ce         (ce),
    .sample_in  (sample_sel),
    .dgain      (dg_a),
    .again      (ag_a),
    .force_zero (~loaded | therm),
    .dac_data   (dac_data),
    .dac_atten  (dac_atten)
  );

  wgsc_relay_timer #(
    .SETTLE_CYC (RELAY_SETTLE_CYC)
  ) u_relay (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .ce          (ce),
    .relay_state (ch_on),
    .settling    (relay_settling)
  );
endmodule
`default_nettype wire

// ### shared/wgsc_consts.vh
// Constants for the waveform generator state control block
`ifndef WGSC_CONSTS_VH
`define WGSC_CONSTS_VH

`define WGSC_REG_CTRL      8'h00
`define WGSC_REG_CFG       8'h04
`define WGSC_REG_DGAIN     8'h08
`define WGSC_REG_AGAIN     8'h0C
`define WGSC_REG_STATUS    8'h10

`define WGSC_CTRL_LOAD     0
`define WGSC_CTRL_OUTEN    1
`define WGSC_CTRL_INIT     2
`define WGSC_CTRL_ABORT    3
`define WGSC_CTRL_SWTRIG   4
`define WGSC_CTRL_RESET    5
`define WGSC_CTRL_COMMIT   6
`define WGSC_CTRL_OUTEN_UPD 7

`define WGSC_CFG_TSRC_LO   0
`define WGSC_CFG_TSRC_HI   1
`define WGSC_CFG_CONT      2
`define WGSC_CFG_CLKIN_EN  3
`define WGSC_CFG_CLKOUT_EN 4
`define WGSC_CFG_FL0_OE    5
`define WGSC_CFG_FL1_OE    6
`define WGSC_CFG_SCLK_EXT  7
`define WGSC_CFG_TB_EXT    8
`define WGSC_CFG_RDIV_LO   16
`define WGSC_CFG_RDIV_HI   23

`define WGSC_TSRC_IMM      2'h0
`define WGSC_TSRC_SW       2'h1
`define WGSC_TSRC_FL0      2'h2
`define WGSC_TSRC_FL1      2'h3

`define WGSC_CFG_RST       9'h000
`define WGSC_RDIV_RST      8'h00
`define WGSC_DGAIN_RST     16'h8000
`define WGSC_AGAIN_RST     16'hFFFF
`define WGSC_ATTEN_STEPS   12

`define WGSC_LED_OFF       2'h0
`define WGSC_LED_AMBER     2'h1
`define WGSC_LED_GREEN     2'h2
`define WGSC_LED_RED       2'h3

`define WGSC_CLK_MHZ       125
`define WGSC_RELAY_SETTLE_MS 10
`define WGSC_RELAY_SETTLE_CYC (`WGSC_RELAY_SETTLE_MS * `WGSC_CLK_MHZ * 1000)

`endif

// ### rtl/wgsc_gain.v
// Digital gain stage and attenuation code for the DAC path
`timescale 1ns/1ps
`default_nettype none
`include "wgsc_consts.vh"
module wgsc_gain (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire [15:0] sample_in,
  input  wire [15:0] dgain,
  input  wire [15:0] again,
  input  wire        force_zero,
  output reg  [15:0] dac_data,
  output reg  [3:0]  dac_atten
);
  // Quarter-decibel steps below full scale of the arbitrary gain
  function [3:0] wgsc_atten_code;
    input [15:0] g;
    reg   [3:0]  c;
    begin
      c = 4'h0;
      if (g < 16'hF8BC) c = 4'h1;
      if (g < 16'hF16E) c = 4'h2;
      if (g < 16'hEAD5) c = 4'h3;
      if (g < 16'hE42C) c = 4'h4;
      if (g < 16'hDDB4) c = 4'h5;
      if (g < 16'hD76B) c = 4'h6;
      if (g < 16'hD14F) c = 4'h7;
      if (g < 16'hCB60) c = 4'h8;
      if (g < 16'hC59D) c = 4'h9;
      if (g < 16'hC003) c = 4'hA;
      if (g < 16'hBA92) c = 4'hB;
      if (g < 16'hB53D) c = 4'hC;
      wgsc_atten_code = c;
    end
  endfunction

  wire signed [32:0] product = $signed(sample_in) * $signed({1'b0, dgain});
  wire signed [17:0] scaled  = product[32:15];
  // Gains above unity would wrap, so clip to the 16-bit range
  wire [15:0] clipped = (scaled > 18'sh07FFF) ? 16'h7FFF :
                        (scaled < -18'sh08000) ? 16'h8000 : scaled[15:0];

  always @(posedge mclk) begin
    if (!rst_n) begin
      dac_data  <= 16'h0000;
      dac_atten <= 4'h0;
    end else if (ce) begin
      dac_data  <= force_zero ? 16'h0000 : clipped;
      dac_atten <= wgsc_atten_code(again);
    end
  end
endmodule
`default_nettype wire

// ### rtl/wgsc_relay_timer.v
// Settling timer started by each switch of the output relay
`timescale 1ns/1ps
`default_nettype none
`include "wgsc_consts.vh"
module wgsc_relay_timer #(
  parameter [20:0] SETTLE_CYC = `WGSC_RELAY_SETTLE_CYC
) (
  input  wire mclk,
  input  wire rst_n,
  input  wire ce,
  input  wire relay_state,
  output reg  settling
);
  reg        prev;
  reg [20:0] cnt;

  always @(posedge mclk) begin
    if (!rst_n) begin
      prev     <= 1'b0;
      cnt      <= 21'h000000;
      settling <= 1'b0;
    end else if (ce) begin
      prev <= relay_state;
      if (prev != relay_state) begin
        // A new switch restarts the full window
        cnt      <= SETTLE_CYC;
        settling <= 1'b1;
      end else if (cnt > 21'h000001) begin
        cnt <= cnt - 21'h000001;
      end else begin
        cnt      <= 21'h000000;
        settling <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/wgsc_far.sv
// Far-side model: external trigger pins and engine completion pulse
`timescale 1ns/1ps
`default_nettype none
module wgsc_far (
  input  wire logic mclk,
  output logic      line0,
  output logic      line1,
  output logic      done_pulse
);
  initial begin
    line0 = 1'b0;
    line1 = 1'b0;
    done_pulse = 1'b0;
  end
  // Pins rest low as driven at start; a low gap follows so the next edge is seen
  task automatic fire(input logic which);
    @(posedge mclk);
    if (which) line1 <= 1'b1;
    else line0 <= 1'b1;
    repeat (4) @(posedge mclk);
    line0 <= 1'b0;
    line1 <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic finish_gen();
    @(posedge mclk);
    done_pulse <= 1'b1;
    @(posedge mclk);
    done_pulse <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### dv/wgsc_chk_sva.sv
// Concurrent checks on the state control top ports
`timescale 1ns/1ps
`default_nettype none
module wgsc_chk #(
  parameter [20:0] RELAY_SETTLE_CYC = 21'd20
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        temp_alarm,
  input wire logic        data_underflow,
  input wire logic        started_evt,
  input wire logic [5:0]  gen_state,
  input wire logic        function_line_zero_o,
  input wire logic        function_line_zero_oe,
  input wire logic [7:0]  bp_trig_oe,
  input wire logic        analog_out_pair_zero_en,
  input wire logic        analog_out_pair_one_en,
  input wire logic        out_term_gnd,
  input wire logic        power_down,
  input wire logic [15:0] dac_data,
  input wire logic        relay_settling,
  input wire logic [1:0]  led_color
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  wire ctrl_wr = psel && penable && pwrite && paddr == 8'h00;
  logic [21:0] run;
  logic [3:0]  hot;
  // Run length restarts on each relay switch, since the timer restarts too
  always_ff @(posedge mclk) begin
    hot <= {hot[2:0], temp_alarm};
    if (!rst_n || !relay_settling || $changed(analog_out_pair_zero_en)) run <= '0;
    else run <= run + 22'd1;
  end
  a_pready_high: assert property (pready) else $error("pready low");
  a_first_brief: assert property (gen_state == 6'h04 |=> gen_state != 6'h04)
    else $error("first-data state held");
  a_started_first: assert property ($rose(gen_state == 6'h04) |-> started_evt)
    else $error("no started event on entry");
  a_done_holds: assert property ((gen_state == 6'h10 && !ctrl_wr) |=>
    gen_state inside {6'h10, 6'h20}) else $error("done left without abort");
  a_done_entry: assert property ($rose(gen_state == 6'h10) |-> $past(gen_state) == 6'h08)
    else $error("done not from generating");
  a_term_inverse: assert property (out_term_gnd == !analog_out_pair_zero_en &&
    analog_out_pair_one_en == analog_out_pair_zero_en) else $error("termination mismatch");
  a_bp_tristate: assert property (bp_trig_oe == 8'h00) else $error("backplane driven");
  a_thermal_off: assert property (power_down && $past(power_down) |->
    !analog_out_pair_zero_en && dac_data == 16'h0000) else $error("output live in shutdown");
  a_relay_start: assert property ($changed(analog_out_pair_zero_en) |-> ##[0:1] relay_settling)
    else $error("no settling after switch");
  a_relay_len: assert property (run <= RELAY_SETTLE_CYC + 2) else $error("settling too long");
  a_line_copy: assert property (function_line_zero_oe |->
    function_line_zero_o == $past(started_evt)) else $error("line copy wrong");
  a_led_wait: assert property (gen_state == 6'h02 && $past(gen_state) == 6'h02 |->
    led_color == 2'h1) else $error("led not amber");
  a_led_error: assert property (gen_state == 6'h20 && $past(gen_state) == 6'h20 |->
    led_color == 2'h3) else $error("led not red");
  a_reset_idle: assert property (@(posedge mclk) disable iff (1'b0) !rst_n |=>
    gen_state == 6'h01) else $error("reset not idle");
  a_dev_reset: assert property (ctrl_wr && pwdata[5] && !data_underflow && hot == 4'h0 &&
    // Power-down follows the thermal latch one cycle later
    !temp_alarm |=> gen_state == 6'h01 ##1 !power_down) else $error("device reset failed");
  c_gen: cover property (gen_state == 6'h08);
  c_done: cover property (gen_state == 6'h10);
  c_err: cover property (gen_state == 6'h20);
endmodule
bind wgsc_top wgsc_chk #(.RELAY_SETTLE_CYC(RELAY_SETTLE_CYC)) chk_u (.*);
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the waveform state control top
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int SETTLE = 20;
  logic mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic temp_alarm = 1'b0, pll_locked = 1'b1, data_underflow = 1'b0, osp_enable = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] eng_sample = 16'h0000, osp_sample = 16'h0000;
  wire logic gen_complete, function_line_zero_i, function_line_one_i, pready, pslverr;
  wire logic function_line_zero_o, function_line_zero_oe, function_line_one_o;
  wire logic function_line_one_oe, clk_out_oe, clk_in_en, sclk_src_ext, tb_tune_ext;
  wire logic engine_run, started_evt, relay_settling, power_down, out_term_gnd;
  wire logic analog_out_pair_zero_en, analog_out_pair_one_en;
  wire logic [31:0] prdata;
  wire logic [7:0] bp_trig_o, bp_trig_oe, rate_div;
  wire logic [15:0] dac_data;
  wire logic [3:0] dac_atten;
  wire logic [1:0] led_color;
  wire logic [5:0] gen_state;
  logic [32:0] exp_q[$], msk_q[$], m;
  int n_fail = 0, check_count = 0, k, t;
  wgsc_top #(.RELAY_SETTLE_CYC(21'd20)) dut_u (.*);
  wgsc_far far_u (.mclk(mclk), .line0(function_line_zero_i), .line1(function_line_one_i),
    .done_pulse(gen_complete));
  always #4 mclk = ~mclk;
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tmo();
    n_fail++;
    test_done();
  endtask
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Note taken at the access edge compares {pslverr, prdata} under the mask
  always @(posedge mclk) begin
    if (psel && penable && pready && msk_q.size() > 0) begin
      m = msk_q.pop_front();
      chk({pslverr, prdata} & m, exp_q.pop_front() & m);
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] mk);
    int n;
    exp_q.push_back(e);
    msk_q.push_back(mk);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) tmo();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err = 1'b0);
    apb(1'b1, a, d, {err, 32'h0}, 33'h1_0000_0000);
  endtask
  task automatic st(input logic [15:0] e, input logic err = 1'b0);
    apb(1'b0, 8'h10, 32'h0, {err, 16'h0000, e}, 33'h1_0000_733F);
  endtask
  function automatic logic [15:0] sv(input logic [5:0] s, input logic [1:0] led);
    return {1'b0, led, 5'b00011, 2'b00, s};
  endfunction
  task automatic wst(input logic [5:0] s);
    k = 0;
    while (gen_state !== s && k < 60) begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (k >= 60) tmo();
  endtask
  task automatic wev();
    k = 0;
    // Step past the edge so a pulse launched there is seen
    #1;
    while (started_evt !== 1'b1 && k < 40) begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (k >= 40) tmo();
  endtask
  // Random sample through the gain path; gains up to unity never saturate
  task automatic gchk(input logic [15:0] g);
    logic signed [15:0] s;
    logic signed [32:0] p;
    s = 16'($urandom);
    p = s * $signed({1'b0, g});
    @(posedge mclk);
    osp_enable <= s[3];
    osp_sample <= s[3] ? s : ~s;
    eng_sample <= s[3] ? ~s : s;
    @(posedge mclk);
    #1;
    chk(dac_data, p[30:15]);
  endtask
  task automatic run_cfg(input logic [31:0] cfg);
    wr(8'h04, cfg);
    wr(8'h00, 32'h40);
    wr(8'h00, 32'h04);
  endtask
  initial begin
    void'($urandom(32'h0A415E10));
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk({analog_out_pair_zero_en, analog_out_pair_one_en, out_term_gnd, dac_data}, 19'h10000);
    chk({clk_out_oe, clk_in_en, function_line_zero_oe, function_line_one_oe, bp_trig_oe}, 0);
    chk({rate_div, sclk_src_ext, tb_tune_ext}, 0);
    st(16'h0101);
    apb(1'b0, 8'h08, 32'h0, 33'h0_0000_8000, 33'h1_0000_FFFF);
    apb(1'b0, 8'h0C, 32'h0, 33'h0_0000_FFFF, 33'h1_0000_FFFF);
    apb(1'b0, 8'h14, 32'h0, {1'b1, 32'h0}, 33'h1_0000_0000);
    $display("reset test done");
    wr(8'h00, 32'h01);
    @(posedge mclk);
    #1;
    chk({analog_out_pair_zero_en, analog_out_pair_one_en, out_term_gnd, dac_atten}, 7'h60);
    t = 0;
    repeat (100) begin
      @(posedge mclk);
      #1;
      t += int'(relay_settling === 1'b1);
    end
    chk(t >= SETTLE - 1 && t <= SETTLE + 1, 1'b1);
    repeat (4) gchk(16'h8000);
    wr(8'h08, 32'h4000);
    repeat (3) gchk(16'h8000);
    wr(8'h0C, 32'h8000);
    wr(8'h00, 32'h40);
    repeat (3) gchk(16'h4000);
    chk(dac_atten, 4'hC);
    $display("load and gain test done");
    run_cfg(32'h04);
    wev();
    chk(gen_state, 6'h04);
    @(posedge mclk);
    #1;
    chk({gen_state, engine_run}, {6'h08, 1'b1});
    t = $urandom & 32'h7FFF;
    wr(8'h08, t);
    repeat (3) gchk(t[15:0]);
    wr(8'h00, 32'h80);
    @(posedge mclk);
    #1;
    chk({analog_out_pair_zero_en, out_term_gnd, gen_state, engine_run}, {2'b01, 6'h08, 1'b1});
    wr(8'h00, 32'h82);
    wr(8'h00, 32'h08);
    st(sv(6'h01, 2'h0));
    $display("immediate test done");
    run_cfg(32'h01);
    repeat (6) @(posedge mclk);
    st(sv(6'h02, 2'h1));
    wr(8'h00, 32'h10);
    wev();
    chk(gen_state, 6'h04);
    wst(6'h08);
    far_u.finish_gen();
    wst(6'h10);
    repeat (5) @(posedge mclk);
    #1;
    chk(gen_state, 6'h10);
    wr(8'h00, 32'h08);
    st(sv(6'h01, 2'h0));
    $display("software trigger test done");
    for (int src = 2; src < 4; src++) begin
      run_cfg(32'h64 | src);
      wst(6'h02);
      fork
        far_u.fire(src[0]);
        begin
          wev();
          chk(gen_state, 6'h04);
        end
      join
      wst(6'h08);
      fork
        far_u.fire(src[0]);
        wev();
      join
      chk(gen_state, 6'h08);
      far_u.finish_gen();
      repeat (3) @(posedge mclk);
      #1;
      chk(gen_state, 6'h08);
      wr(8'h00, 32'h08);
    end
    $display("pin trigger test done");
    run_cfg(32'h04);
    wst(6'h08);
    @(posedge mclk);
    data_underflow <= 1'b1;
    @(posedge mclk);
    data_underflow <= 1'b0;
    wst(6'h20);
    st(sv(6'h20, 2'h3), 1'b1);
    wr(8'h00, 32'h08);
    @(posedge mclk);
    #1;
    chk(gen_state, 6'h20);
    wr(8'h00, 32'h20);
    st(sv(6'h01, 2'h0));
    @(posedge mclk);
    temp_alarm <= 1'b1;
    k = 0;
    while (power_down !== 1'b1 && k < 20) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 20) tmo();
    temp_alarm <= 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    chk({power_down, analog_out_pair_zero_en, dac_data}, 18'h20000);
    wr(8'h04, 32'h04, 1'b1);
    apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0}, 33'h1_0000_0000);
    wr(8'h00, 32'h20);
    st(sv(6'h01, 2'h0));
    repeat (2) @(posedge mclk);
    #1;
    chk(analog_out_pair_zero_en, 1'b1);
    $display("error test done");
    test_done();
  end
endmodule
`default_nettype wire
